// File: rtl/erdl_pkg.sv
package erdl_pkg;
    // non-volatile memory geometry (bytes, 13-bit address)
    localparam int ERDL_NV_AW = 13;
    localparam int ERDL_REG_AW = 7;
    // default area: register reset values start at byte 0x40
    localparam logic [12:0] ERDL_DEF_BASE = 13'h0040;
    // protocol settings area: tx 16 bytes, rx 8 bytes per protocol
    localparam logic [12:0] ERDL_RSP_BASE = 13'h1c00;
    localparam logic [6:0] ERDL_TX_REG_BASE = 7'h28;
    localparam logic [6:0] ERDL_RX_REG_BASE = 7'h38;
    localparam logic [7:0] ERDL_TX_LEN = 8'h10;
    localparam logic [7:0] ERDL_RX_LEN = 8'h08;
    localparam logic [4:0] ERDL_RSP_STRIDE_SH = 5'h05;
    // number of working registers covered by the startup copy
    localparam logic [7:0] ERDL_DEF_LEN = 8'h60;
    // crystal reference and independent core clock
    localparam real ERDL_XTAL_MHZ = 27.12;
    localparam real ERDL_CLK_MHZ = 100.0;
    // nonvolatile read latency in cycles of clk
    localparam logic [3:0] ERDL_NV_LAT = 4'h2;
    // crystal divider: one carrier tick per two crystal periods
    localparam int ERDL_XDIV_W = 1;
endpackage

// File: rtl/erdl_xtal_div.sv
`timescale 1ns/10ps
// divides the synchronised crystal into carrier and mixer ticks
module erdl_xtal_div
    import erdl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic xtal_sync,
    output logic carrier_tick,
    output logic mixer_tick
);
    typedef struct packed {
        logic prev;
        logic [ERDL_XDIV_W-1:0] cnt;
        logic car;
        logic mix;
    } erdl_div_s;
    erdl_div_s cur_ff;
    erdl_div_s nxt_ff;

    ////////////////////////////////////////////////////////////////
    // rising edge of crystal drives both tick streams
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.prev = xtal_sync;
        nxt_ff.car = 1'b0;
        nxt_ff.mix = 1'b0;
        if (xtal_sync && !cur_ff.prev) begin
            nxt_ff.mix = 1'b1;
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
            // carrier at half crystal rate
            nxt_ff.car = (cur_ff.cnt == '1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign carrier_tick = cur_ff.car;
    assign mixer_tick = cur_ff.mix;
endmodule // erdl_xtal_div

// File: rtl/erdl_loader.sv
`timescale 1ns/10ps
// Functional notes
// - copy stored defaults into registers after startup
// - write only read/write or dynamic bits
// - source address follows protocol, user reprogrammable
// - rewritten stored defaults used on next copy
// - protocol load command copies protocol settings
// - factory programmed defaults always valid
// - timing derived from 27.12 MHz crystal
// - register load command copies user-area settings
module erdl_loader
    import erdl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic startup_done,
    input wire logic xtal_in,
    input wire logic [12:0] def_src_addr,
    input wire logic [7:0] proto_sel,
    input wire logic protocol_preset_load,
    input wire logic register_preset_load,
    input wire logic [12:0] user_src_addr,
    input wire logic [6:0] user_dst_reg,
    input wire logic [7:0] user_len,
    output logic nv_rd,
    output logic [12:0] nv_addr,
    input wire logic [7:0] nv_rdata,
    output logic reg_we,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic [7:0] reg_wmask,
    input wire logic [7:0] reg_wr_bits,
    output logic host_hold,
    output logic busy,
    output logic done_pulse,
    output logic carrier_tick,
    output logic mixer_tick
);
    // one-hot copy states
    typedef enum logic [3:0] {
        ERDL_IDLE = 4'b0001,
        ERDL_READ = 4'b0010,
        ERDL_WAIT = 4'b0100,
        ERDL_WRITE = 4'b1000
    } erdl_state_e;

    // whole state of the loader except the divider's own: one register, filled by one process
    typedef struct packed {
        erdl_state_e st;
        logic [1:0] sd_sync;
        logic [1:0] xt_sync;
        logic boot_done;
        logic rx_phase;
        logic [12:0] src;
        logic [6:0] dst;
        logic [7:0] left;
        logic [3:0] lat;
        logic rd;
        logic we;
        logic [6:0] waddr;
        logic [7:0] wdata;
        logic [7:0] wmask;
        logic hold;
        logic busy;
        logic done;
    } erdl_ctl_s;

    erdl_ctl_s cur_ff;
    erdl_ctl_s nxt_ff;
    // first byte of the chosen protocol's settings
    logic [12:0] rsp_base;

    ////////////////////////////////////////////////////////////////
    // protocol set base: fixed stride per protocol index
    // only the low five index bits are used: the settings area holds
    // 32 sets, and a wider index would wrap the 13-bit address back
    // into the key area, which must never reach the registers
    // protocol picks source
    assign rsp_base = ERDL_RSP_BASE
        + 13'({8'h00, proto_sel[4:0]} << ERDL_RSP_STRIDE_SH);

    // copy engine; one byte per read/wait/write round, four cycles
    // a byte; slow, but the memory port then needs no handshake of its
    // own and the register file sees at most one write per round
    always_comb begin
        nxt_ff = cur_ff;
        // two-stage synchronisers for the asynchronous pins; only the
        // second stage is read by the engine or the divider
        nxt_ff.sd_sync = {cur_ff.sd_sync[0], startup_done};
        nxt_ff.xt_sync = {cur_ff.xt_sync[0], xtal_in};
        // strobes last one cycle unless a state sets them again
        nxt_ff.rd = 1'b0;
        nxt_ff.we = 1'b0;
        nxt_ff.done = 1'b0;
        case (cur_ff.st)
            ERDL_IDLE: begin
                // commands are only looked at here: a request raised
                // during a copy or before the startup copy is dropped,
                // and one still high after done starts a fresh copy
                if (!cur_ff.boot_done && cur_ff.sd_sync[1]) begin
                    // factory image is source
                    // factory or rewritten image, read afresh each copy
                    nxt_ff.src = def_src_addr;
                    nxt_ff.dst = 7'h00;
                    nxt_ff.left = ERDL_DEF_LEN;
                    nxt_ff.rx_phase = 1'b0;
                    nxt_ff.st = ERDL_READ;
                    nxt_ff.busy = 1'b1;
                end else if (cur_ff.boot_done && protocol_preset_load) begin
                    nxt_ff.src = rsp_base;
                    nxt_ff.dst = ERDL_TX_REG_BASE;
                    nxt_ff.left = ERDL_TX_LEN;
                    nxt_ff.rx_phase = 1'b1;
                    nxt_ff.st = ERDL_READ;
                    nxt_ff.busy = 1'b1;
                end else if (cur_ff.boot_done && register_preset_load
                    && user_len != 8'h00) begin
                    // user area copy
                    // zero length refused: the count would wrap and copy 256 bytes
                    nxt_ff.src = user_src_addr;
                    nxt_ff.dst = user_dst_reg;
                    nxt_ff.left = user_len;
                    nxt_ff.rx_phase = 1'b0;
                    nxt_ff.st = ERDL_READ;
                    nxt_ff.busy = 1'b1;
                end
            end
            ERDL_READ: begin
                nxt_ff.rd = 1'b1;
                nxt_ff.lat = ERDL_NV_LAT;
                nxt_ff.st = ERDL_WAIT;
                // target shown early
                // the register file answers reg_wr_bits for reg_addr, so
                // the target goes out during the wait and the mask taken
                // at the write belongs to the register being written
                nxt_ff.waddr = cur_ff.dst;
            end
            ERDL_WAIT: begin
                // memory latency: data is valid when the count runs out
                nxt_ff.lat = cur_ff.lat - 4'h1;
                if (cur_ff.lat == 4'h1) begin
                    nxt_ff.st = ERDL_WRITE;
                end
            end
            ERDL_WRITE: begin
                nxt_ff.we = 1'b1;
                nxt_ff.waddr = cur_ff.dst;
                nxt_ff.wdata = nv_rdata;
                nxt_ff.wmask = reg_wr_bits;
                // source and target step together, once per written
                // byte, so a cut copy never skips or repeats a byte
                nxt_ff.src = cur_ff.src + 13'h0001;
                nxt_ff.dst = cur_ff.dst + 7'h01;
                nxt_ff.left = cur_ff.left - 8'h01;
                nxt_ff.st = ERDL_READ;
                if (cur_ff.left == 8'h01) begin
                    if (cur_ff.rx_phase) begin
                        // rx part follows tx in the same set
                        // the source keeps counting; only the register
                        // target jumps to the rx block
                        nxt_ff.rx_phase = 1'b0;
                        nxt_ff.dst = ERDL_RX_REG_BASE;
                        nxt_ff.left = ERDL_RX_LEN;
                    end else begin
                        // done, busy and hold move with the last write
                        nxt_ff.st = ERDL_IDLE;
                        nxt_ff.busy = 1'b0;
                        nxt_ff.done = 1'b1;
                        nxt_ff.boot_done = 1'b1;
                        nxt_ff.hold = 1'b0;
                    end
                end
            end
            default: begin
                // illegal code: back to idle, the copy is lost
                nxt_ff.st = ERDL_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // host held from reset
    // a reset in mid-copy drops the copy; the startup copy runs again
    // once startup_done is seen through the synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff <= '{st: ERDL_IDLE, hold: 1'b1, default: '0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ports straight from the state register, no combinational path
    assign nv_rd = cur_ff.rd;
    assign nv_addr = cur_ff.src;
    assign reg_we = cur_ff.we;
    assign reg_addr = cur_ff.waddr;
    assign reg_wdata = cur_ff.wdata;
    assign reg_wmask = cur_ff.wmask;
    assign host_hold = cur_ff.hold;
    assign busy = cur_ff.busy;
    assign done_pulse = cur_ff.done;

    ////////////////////////////////////////////////////////////////
    // crystal derived ticks
    // the divider sees only the synchronised crystal; ticks are one clk
    // wide and, with clk well above the crystal, never merge
    erdl_xtal_div u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .xtal_sync(cur_ff.xt_sync[1]),
        .carrier_tick(carrier_tick),
        .mixer_tick(mixer_tick)
    );
endmodule // erdl_loader

// File: dv/erdl_loader_properties.sv
`timescale 1ns/10ps
// output timing of the loader, tied to nv reads and mask input
module erdl_loader_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic nv_rd,
    input wire logic [7:0] nv_rdata,
    input wire logic reg_we,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_wmask,
    input wire logic [7:0] reg_wr_bits,
    input wire logic host_hold,
    input wire logic busy,
    input wire logic done_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_hold_until_done: assert property ($fell(host_hold) |-> done_pulse)
        else $error("host hold dropped early");
    a_read_then_write: assert property (nv_rd |-> ##3 reg_we)
        else $error("no write after read");
    a_write_has_read: assert property (reg_we |-> $past(nv_rd, 3))
        else $error("write without read");
    a_data_from_nv: assert property (
        reg_we |-> reg_wdata == $past(nv_rdata))
        else $error("write data not from memory");
    a_mask_rw_bits: assert property (
        reg_we |-> reg_wmask == $past(reg_wr_bits))
        else $error("write mask wrong");
    a_target_early: assert property (
        reg_we |-> reg_addr == $past(reg_addr, 3))
        else $error("write target not shown during the wait");
    a_busy_on_read: assert property (nv_rd |-> busy)
        else $error("read while idle");
    a_done_last_write: assert property (done_pulse |-> reg_we && !busy)
        else $error("done without last write");
    a_dst_ascends: assert property (reg_we && $past(reg_we, 4) &&
        !$past(done_pulse, 4) |-> reg_addr == $past(reg_addr, 4) + 7'h01)
        else $error("register address not ascending");
endmodule // erdl_loader_properties
bind erdl_loader erdl_loader_properties u_props (.clk(clk), .sys_rst(sys_rst),
    .nv_rd(nv_rd), .nv_rdata(nv_rdata), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .reg_wr_bits(reg_wr_bits),
    .host_hold(host_hold), .busy(busy), .done_pulse(done_pulse));

// File: dv/erdl_loader_bench.sv
`timescale 1ns/10ps
module erdl_loader_bench
    import erdl_pkg::*;
;
    logic clk, sys_rst, startup_done, xtal_in, protocol_preset_load;
    logic register_preset_load, nv_rd, reg_we, host_hold, busy, done_pulse;
    logic carrier_tick, mixer_tick;
    logic [12:0] def_src_addr, user_src_addr, nv_addr;
    logic [7:0] proto_sel, user_len, nv_rdata, reg_wdata, reg_wmask;
    logic [7:0] reg_wr_bits, salt, mask_key;
    logic [6:0] user_dst_reg, reg_addr;
    int bad_count, checks_done;
    erdl_loader dut (.clk(clk), .sys_rst(sys_rst), .startup_done(startup_done),
        .xtal_in(xtal_in), .def_src_addr(def_src_addr), .proto_sel(proto_sel),
        .protocol_preset_load(protocol_preset_load), .user_len(user_len),
        .register_preset_load(register_preset_load), .nv_rdata(nv_rdata),
        .user_src_addr(user_src_addr), .user_dst_reg(user_dst_reg),
        .nv_rd(nv_rd), .nv_addr(nv_addr), .reg_we(reg_we), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .busy(busy),
        .reg_wr_bits(reg_wr_bits), .host_hold(host_hold),
        .done_pulse(done_pulse), .carrier_tick(carrier_tick),
        .mixer_tick(mixer_tick));
    ////////////////////////////////////////////////////////////////////////
    // clocks: core at 100 MHz, crystal free running and unrelated
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        xtal_in = 1'b0;
        forever #18.44 xtal_in = ~xtal_in;
    end
    // stored content depends on salt so a rewrite shows up
    function automatic logic [7:0] nvm(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]} ^ salt;
    endfunction
    // nv model answers from the held address, well inside the latency
    always @(posedge clk) nv_rdata <= #1 nvm(nv_addr);
    // register file: writable bits differ per register, so a mask
    // taken for the wrong register shows up
    assign reg_wr_bits = mask_key ^ {1'b0, reg_addr};
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // follows one copy until done; every byte goes src+k to dst+k
    task copy(input logic [12:0] src, input logic [6:0] dst, input int n);
        int k, t;
        k = 0;
        for (t = 0; t < 3000 && done_pulse !== 1'b1; t++) begin
            @(posedge clk);
            #1;
            if (nv_rd === 1'b1) begin
                chk("nv_addr", 16'(src + 13'(k)), {3'h0, nv_addr});
            end
            if (reg_we === 1'b1) begin
                chk("reg_addr", 16'(dst + k), {9'h0, reg_addr});
                chk("reg_wdata", {8'h0, nvm(src + 13'(k))},
                    {8'h0, reg_wdata});
                chk("reg_wmask", {8'h0, mask_key ^ {1'b0, 7'(dst + k)}},
                    {8'h0, reg_wmask});
                k++;
            end
        end
        if (t >= 3000) begin
            chk("copy finished", 16'h0001, 16'h0000);
            results;
        end
        chk("byte count", 16'(n), 16'(k));
    endtask
    // reset, then startup copy from a chosen default area
    task boot(input logic [12:0] src, input logic [7:0] s);
        salt = s;
        def_src_addr = src;
        mask_key = 8'h3c;
        startup_done = 1'b0;
        sys_rst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("host_hold", 16'h0001, {15'h0, host_hold});
        startup_done = 1'b1;
        copy(src, 7'h00, ERDL_DEF_LEN);
        chk("host_hold", 16'h0000, {15'h0, host_hold});
        $display("boot copy from %h done", src);
    endtask
    // both commands at once: protocol load has priority; a non-zero
    // user length keeps the lower command live so priority is tested
    task proto_load(input logic [7:0] p);
        proto_sel = p;
        mask_key = 8'hc3;
        user_len = 8'h05;
        protocol_preset_load = 1'b1;
        register_preset_load = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        protocol_preset_load = 1'b0;
        register_preset_load = 1'b0;
        copy(ERDL_RSP_BASE + ({5'h00, p} << ERDL_RSP_STRIDE_SH),
            ERDL_TX_REG_BASE, ERDL_TX_LEN + ERDL_RX_LEN);
        $display("protocol %h load done", p);
    endtask
    // user area load, then a zero length request that must be ignored
    task user_load;
        user_src_addr = 13'h0123;
        user_dst_reg = 7'h10;
        user_len = 8'h05;
        register_preset_load = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        register_preset_load = 1'b0;
        copy(13'h0123, 7'h10, 5);
        user_len = 8'h00;
        register_preset_load = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        register_preset_load = 1'b0;
        chk("busy", 16'h0000, {15'h0, busy});
        $display("register load done");
    endtask
    // mixer ticks per crystal rise, carrier at half that rate
    task xtal_check;
        int m, c;
        m = 0;
        c = 0;
        repeat (400) begin
            @(posedge clk);
            #1;
            m += (mixer_tick === 1'b1);
            c += (carrier_tick === 1'b1);
        end
        chk("mixer ticks seen", 16'h0001, 16'(m > 100 && m < 116));
        chk("carrier half rate", 16'h0001,
            16'(m - 2 * c <= 1 && 2 * c - m <= 1));
        $display("crystal ticks done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        checks_done = 0;
        {protocol_preset_load, register_preset_load, user_len} = '0;
        {proto_sel, user_src_addr, user_dst_reg, salt} = '0;
        boot(ERDL_DEF_BASE, 8'h00);
        proto_load(8'h03);
        proto_load(8'h00);
        user_load;
        xtal_check;
        boot(13'h0200, 8'h5a);
        results;
    end
endmodule // erdl_loader_bench
